// ---- hdl/gdc_top.sv ----
// Dataway command decoder, setting storage and sixteen channels
module gdc_top import gdc_pkg::*; #(
	parameter int NCH = GDC_CHANNELS,
	parameter int CW = CODE_W
) (
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic i_n,
	input wire logic [4:0] i_f,
	input wire logic [3:0] i_a,
	input wire logic [CW-1:0] i_w,
	input wire logic i_s1,
	input wire logic i_s2,
	input wire logic i_c,
	input wire logic i_z,
	input wire logic [NCH-1:0] i_chan_in,
	input wire logic i_abort_input,
	input wire logic i_inhibit_input,
	input wire logic i_fire_all,
	input wire logic [1:0] i_layout_switches,
	output logic o_x,
	output logic o_q,
	output logic [NCH-1:0] o_chan_out,
	output logic o_monitor_output_a,
	output logic o_monitor_output_b,
	output logic [NCH-1:0] o_presence_led,
	output logic o_layout_led
);
	localparam int SYNC_W = 1 + 5 + 4 + CW + 4;
	localparam int PIN_W = NCH + 5;

	logic [SYNC_W-1:0] bus_s;
	logic n_s;
	logic [4:0] f_s;
	logic [3:0] a_s;
	logic [CW-1:0] w_s;
	logic s1_s;
	logic s2_s;
	logic c_s;
	logic z_s;
	logic [PIN_W-1:0] pin_s;
	logic [NCH-1:0] in_s;
	logic abort_s;
	logic inhibit_s;
	logic fire_s;
	logic [1:0] layout_s;

	logic s1_prev_q;
	logic s2_prev_q;
	logic s1_rise;
	logic s2_rise;
	logic cmd_ok;
	logic do_cmd;
	logic mod_rst_q;
	logic test_pulse_q;
	logic fire_prev_q;
	logic fire_evt;
	logic single_layout;

	logic [CW-1:0] stage_delay_q [NCH];
	logic [CW-1:0] stage_width_q [NCH];
	logic [CW-1:0] active_delay_q [NCH];
	logic [CW-1:0] active_width_q [NCH];
	logic [3:0] mon_sel_q;

	logic [NCH-1:0] src;
	logic [NCH-1:0] src_prev_q;
	logic [NCH-1:0] trigger;
	logic [NCH-1:0] gate;
	logic chan_clear;

	logic [STEP_CNT_W-1:0] step_cnt_q;
	logic step_q;

	// All dataway lines arrive unclocked, so they pass a synchroniser together
	gdc_sync #(
		.WIDTH(SYNC_W)
	) u_bus_sync (
		.i_clock(i_clock),
		.i_rstn(i_rstn),
		.i_async({i_n, i_f, i_a, i_w, i_s1, i_s2, i_c, i_z}),
		.o_sync(bus_s)
	);

	assign {n_s, f_s, a_s, w_s, s1_s, s2_s, c_s, z_s} = bus_s;

	gdc_sync #(
		.WIDTH(PIN_W)
	) u_pin_sync (
		.i_clock(i_clock),
		.i_rstn(i_rstn),
		.i_async({i_chan_in, i_abort_input, i_inhibit_input, i_fire_all, i_layout_switches}),
		.o_sync(pin_s)
	);

	assign {in_s, abort_s, inhibit_s, fire_s, layout_s} = pin_s;

	// Strobe edges; data lines are settled well before S1 on the dataway
	assign s1_rise = s1_s && !s1_prev_q;
	assign s2_rise = s2_s && !s2_prev_q;
	assign cmd_ok = gdc_cmd_valid(f_s, a_s);
	assign do_cmd = s1_rise && n_s && cmd_ok;
	assign single_layout = (layout_s == LAYOUT_SINGLE);
	assign fire_evt = (fire_s && !fire_prev_q) || test_pulse_q;
	assign chan_clear = abort_s || mod_rst_q;

	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			s1_prev_q <= 1'b0;
			s2_prev_q <= 1'b0;
			fire_prev_q <= 1'b0;
		end else begin
			s1_prev_q <= s1_s;
			s2_prev_q <= s2_s;
			fire_prev_q <= fire_s;
		end
	end

	// X and Q follow the decode for as long as the station is addressed
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			o_x <= 1'b0;
			o_q <= 1'b0;
		end else begin
			o_x <= n_s && cmd_ok;
			o_q <= n_s && cmd_ok;
		end
	end

	// Module reset from function 9 at S1 or from clear/initialise at S2
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			mod_rst_q <= 1'b0;
		end else begin
			mod_rst_q <= (do_cmd && f_s == FN_RESET) || (s2_rise && (c_s || z_s));
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			test_pulse_q <= 1'b0;
		end else begin
			test_pulse_q <= do_cmd && f_s == FN_TEST;
		end
	end

	// Staging store models battery-backed memory: no reset touches it
	always_ff @(posedge i_clock) begin
		if (do_cmd && f_s == FN_DELAY) begin
			stage_delay_q[a_s] <= w_s;
		end
		if (do_cmd && f_s == FN_WIDTH) begin
			stage_width_q[a_s] <= w_s;
		end
	end

	// Channels see only transferred values; reset forces a new transfer
	always_ff @(posedge i_clock) begin
		if (!i_rstn || mod_rst_q) begin
			for (int k = 0; k < NCH; k++) begin
				active_delay_q[k] <= SETTING_RESET;
				active_width_q[k] <= SETTING_RESET;
			end
		end else if (do_cmd && f_s == FN_TRANSFER) begin
			for (int k = 0; k < NCH; k++) begin
				active_delay_q[k] <= stage_delay_q[k];
				active_width_q[k] <= stage_width_q[k];
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rstn || mod_rst_q) begin
			mon_sel_q <= MONSEL_RESET;
		end else if (do_cmd && f_s == FN_SELECT) begin
			mon_sel_q <= a_s;
		end
	end

	// Step enable divider; one step is one code count
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			step_cnt_q <= '0;
			step_q <= 1'b0;
		end else if (step_cnt_q == STEP_LAST) begin
			step_cnt_q <= '0;
			step_q <= 1'b1;
		end else begin
			step_cnt_q <= step_cnt_q + 1'b1;
			step_q <= 1'b0;
		end
	end

	// Upper half borrows the lower inputs in the eight-input layout
	always_comb begin
		src = in_s;
		if (!single_layout) begin
			src[NCH-1:GDC_HALF] = in_s[GDC_HALF-1:0];
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			src_prev_q <= '0;
		end else begin
			src_prev_q <= src;
		end
	end

	assign trigger = (src & ~src_prev_q) | {NCH{fire_evt}};

	for (genvar k = 0; k < NCH; k++) begin : g_chan
		gdc_channel #(
			.CW(CW)
		) u_chan (
			.i_clock(i_clock),
			.i_rstn(i_rstn),
			.i_step(step_q),
			.i_trigger(trigger[k]),
			.i_clear(chan_clear),
			.i_inhibit(inhibit_s),
			.i_delay(active_delay_q[k]),
			.i_width(active_width_q[k]),
			.o_gate(gate[k])
		);
	end

	assign o_chan_out = gate;

	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			o_monitor_output_a <= 1'b0;
			o_monitor_output_b <= 1'b0;
		end else begin
			o_monitor_output_a <= gate[mon_sel_q];
			o_monitor_output_b <= gate[mon_sel_q];
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			o_presence_led <= '0;
			o_layout_led <= 1'b0;
		end else begin
			o_presence_led <= in_s;
			o_layout_led <= single_layout;
		end
	end

	property p_valid_answers;
		@(posedge i_clock) disable iff (!i_rstn)
		(n_s && cmd_ok) |=> (o_x && o_q);
	endproperty
	a_valid_answers: assert property (p_valid_answers) else $error("valid function not answered");

	property p_invalid_silent;
		@(posedge i_clock) disable iff (!i_rstn)
		(!n_s || !cmd_ok) |=> (!o_x && !o_q);
	endproperty
	a_invalid_silent: assert property (p_invalid_silent) else $error("answer to invalid function");

	property p_delay_write;
		@(posedge i_clock) disable iff (!i_rstn)
		(do_cmd && f_s == FN_DELAY) |=> stage_delay_q[$past(a_s)] == $past(w_s);
	endproperty
	a_delay_write: assert property (p_delay_write) else $error("delay not staged");

	property p_width_write;
		@(posedge i_clock) disable iff (!i_rstn)
		(do_cmd && f_s == FN_WIDTH) |=> stage_width_q[$past(a_s)] == $past(w_s);
	endproperty
	a_width_write: assert property (p_width_write) else $error("width not staged");

	property p_transfer;
		@(posedge i_clock) disable iff (!i_rstn)
		(do_cmd && f_s == FN_TRANSFER && !mod_rst_q)
			|=> active_delay_q[0] == $past(stage_delay_q[0])
			&& active_width_q[NCH-1] == $past(stage_width_q[NCH-1]);
	endproperty
	a_transfer: assert property (p_transfer) else $error("transfer did not load channels");

	property p_select;
		@(posedge i_clock) disable iff (!i_rstn)
		(do_cmd && f_s == FN_SELECT && !mod_rst_q) |=> mon_sel_q == $past(a_s);
	endproperty
	a_select: assert property (p_select) else $error("monitor selection wrong");

	sequence s_reset_cmd;
		(do_cmd && f_s == FN_RESET) || (s2_rise && (c_s || z_s));
	endsequence
	property p_module_reset;
		@(posedge i_clock) disable iff (!i_rstn)
		s_reset_cmd |=> mod_rst_q ##1 (mon_sel_q == MONSEL_RESET && o_chan_out == '0);
	endproperty
	a_module_reset: assert property (p_module_reset) else $error("module reset missed");

	property p_layout_map;
		@(posedge i_clock) disable iff (!i_rstn)
		!single_layout |-> src[NCH-1:GDC_HALF] == src[GDC_HALF-1:0];
	endproperty
	a_layout_map: assert property (p_layout_map) else $error("eight-input mapping broken");

	property p_test_fires;
		@(posedge i_clock) disable iff (!i_rstn)
		(do_cmd && f_s == FN_TEST) |=> trigger == {NCH{1'b1}};
	endproperty
	a_test_fires: assert property (p_test_fires) else $error("test pulse missed");

	property p_abort;
		@(posedge i_clock) disable iff (!i_rstn)
		abort_s |-> ##ABORT_DELAY_CYC o_chan_out == '0;
	endproperty
	a_abort: assert property (p_abort) else $error("abort left an output on");
endmodule

// ---- hdl/gdc_pkg.sv ----
// Shared constants, types and decode functions for the gate and delay controller
package gdc_pkg;
	localparam int GDC_CHANNELS = 16;
	localparam int GDC_HALF = 8;
	localparam int CODE_W = 8;
	localparam int CODE_STEPS = 256;
	localparam int CLK_PERIOD_NS = 40;
	localparam int FULL_SCALE_NS = 500;
	localparam int STEP_NS = 2;
	// Clock is far coarser than one step, so each step takes at least one cycle
	localparam int STEP_CYC = (STEP_NS / CLK_PERIOD_NS > 0) ? STEP_NS / CLK_PERIOD_NS : 1;
	localparam int ABORT_DELAY_NS = 10;
	localparam int ABORT_DELAY_CYC =
		(ABORT_DELAY_NS / CLK_PERIOD_NS > 0) ? ABORT_DELAY_NS / CLK_PERIOD_NS : 1;
	localparam int INHIBIT_MIN_NS = 12;
	localparam int INHIBIT_LEAD_NS = 13;
	localparam int STEP_CNT_W = 8;
	localparam logic [STEP_CNT_W-1:0] STEP_LAST = STEP_CNT_W'(STEP_CYC - 1);

	localparam logic [4:0] FN_RESET = 5'h09;
	localparam logic [4:0] FN_DELAY = 5'h10;
	localparam logic [4:0] FN_WIDTH = 5'h11;
	localparam logic [4:0] FN_SELECT = 5'h12;
	localparam logic [4:0] FN_TRANSFER = 5'h13;
	localparam logic [4:0] FN_TEST = 5'h19;
	localparam logic [3:0] SUBADDR_ZERO = 4'h0;
	localparam logic [1:0] LAYOUT_SINGLE = 2'h3;
	localparam logic [3:0] MONSEL_RESET = 4'h0;
	localparam logic [CODE_W-1:0] SETTING_RESET = 8'h00;

	typedef enum logic [2:0] {
		CH_IDLE = 3'b001,
		CH_DELAY = 3'b010,
		CH_GATE = 3'b100
	} gdc_chan_state_type;

	// Function and subaddress pairs that the module answers
	function automatic logic gdc_cmd_valid(input logic [4:0] f, input logic [3:0] a);
		if (f == FN_DELAY || f == FN_WIDTH || f == FN_SELECT || f == FN_RESET) begin
			return 1'b1;
		end else if ((f == FN_TRANSFER || f == FN_TEST) && a == SUBADDR_ZERO) begin
			return 1'b1;
		end else begin
			return 1'b0;
		end
	endfunction
endpackage

// ---- hdl/gdc_sync.sv ----
// Two-stage synchroniser for a bundle of asynchronous pins
module gdc_sync #(
	parameter int WIDTH = 1
) (
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			meta_q <= '0;
			o_sync <= '0;
		end else begin
			meta_q <= i_async;
			o_sync <= meta_q;
		end
	end
endmodule

// ---- hdl/gdc_channel.sv ----
// One channel: delay countdown then gate countdown, with abort and inhibit
module gdc_channel import gdc_pkg::*; #(
	parameter int CW = CODE_W
) (
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic i_step,
	input wire logic i_trigger,
	input wire logic i_clear,
	input wire logic i_inhibit,
	input wire logic [CW-1:0] i_delay,
	input wire logic [CW-1:0] i_width,
	output logic o_gate
);
	gdc_chan_state_type state_q;
	logic [CW-1:0] count_q;
	logic leading;

	// Gate would start now; the inhibit level decides whether it may
	assign leading = (state_q == CH_DELAY) && i_step && (count_q == '0);

	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			state_q <= CH_IDLE;
			count_q <= '0;
			o_gate <= 1'b0;
		end else if (i_clear) begin
			// Abort ends pending delays and running gates alike
			state_q <= CH_IDLE;
			count_q <= '0;
			o_gate <= 1'b0;
		end else begin
			case (state_q)
				CH_IDLE: begin
					if (i_trigger) begin
						state_q <= CH_DELAY;
						count_q <= i_delay;
					end
				end
				CH_DELAY: begin
					if (leading && i_inhibit) begin
						state_q <= CH_IDLE;
					end else if (leading) begin
						state_q <= CH_GATE;
						count_q <= i_width;
						o_gate <= 1'b1;
					end else if (i_step) begin
						count_q <= count_q - 1'b1;
					end
				end
				CH_GATE: begin
					if (i_step && count_q == '0) begin
						state_q <= CH_IDLE;
						o_gate <= 1'b0;
					end else if (i_step) begin
						count_q <= count_q - 1'b1;
					end
				end
				default: begin
					state_q <= CH_IDLE;
					o_gate <= 1'b0;
				end
			endcase
		end
	end

	property p_inhibit_blocks;
		@(posedge i_clock) disable iff (!i_rstn)
		(leading && i_inhibit && !i_clear) |=> !o_gate [*2];
	endproperty
	a_inhibit_blocks: assert property (p_inhibit_blocks) else $error("gate opened under inhibit");

	property p_clear_ends;
		@(posedge i_clock) disable iff (!i_rstn)
		i_clear |=> (!o_gate && state_q == CH_IDLE);
	endproperty
	a_clear_ends: assert property (p_clear_ends) else $error("abort did not end channel");

	sequence s_started;
		state_q == CH_IDLE && i_trigger && !i_clear;
	endsequence
	property p_trigger_delays;
		@(posedge i_clock) disable iff (!i_rstn)
		s_started |=> (state_q == CH_DELAY && !o_gate);
	endproperty
	a_trigger_delays: assert property (p_trigger_delays) else $error("no delay after trigger");
endmodule

// ---- bench/gdc_dataway_model.sv ----
// Dataway controller model that issues commands to the module
module gdc_dataway_model (
	input wire logic i_clock,
	input wire logic i_x,
	input wire logic i_q,
	output logic o_n,
	output logic [4:0] o_f,
	output logic [3:0] o_a,
	output logic [7:0] o_w,
	output logic o_s1,
	output logic o_s2,
	output logic o_c,
	output logic o_z
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_n = 1'b0;
		o_f = 5'h00;
		o_a = 4'h0;
		o_w = 8'h00;
		o_s1 = 1'b0;
		o_s2 = 1'b0;
		o_c = 1'b0;
		o_z = 1'b0;
	end
	// Lines settle five clocks before S1 and stay through it; xq is sampled before S1
	task automatic cmd(input logic n, input logic [4:0] f, input logic [3:0] a,
		input logic [7:0] w, output logic [1:0] xq);
		@(posedge i_clock);
		o_n <= n;
		o_f <= f;
		o_a <= a;
		o_w <= w;
		repeat (5) @(posedge i_clock);
		xq = {i_x, i_q};
		o_s1 <= 1'b1;
		repeat (3) @(posedge i_clock);
		o_s1 <= 1'b0;
		repeat (4) @(posedge i_clock);
		// Released lines do not keep their last value
		o_n <= 1'b0;
		o_f <= ~f;
		o_a <= ~a;
		o_w <= ~w;
		repeat (4) @(posedge i_clock);
	endtask
	// Clear or initialise, taken at S2
	task automatic clear(input logic use_z);
		@(posedge i_clock);
		o_c <= ~use_z;
		o_z <= use_z;
		repeat (4) @(posedge i_clock);
		o_s2 <= 1'b1;
		repeat (3) @(posedge i_clock);
		o_s2 <= 1'b0;
		repeat (3) @(posedge i_clock);
		o_c <= 1'b0;
		o_z <= 1'b0;
		repeat (4) @(posedge i_clock);
	endtask
endmodule

// ---- bench/test_gate_delay_channel_control.sv ----
// Self-checking testbench for the gate and delay controller
module test_gate_delay_channel_control;
	timeunit 1ns;
	timeprecision 1ps;
	import gdc_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic n, s1, s2, c, z, x, q, abort_in = 1'b0, inhibit = 1'b0, fire = 1'b0;
	logic [4:0] f;
	logic [3:0] a;
	logic [7:0] w;
	logic [15:0] chan_in = 16'h0000;
	logic [15:0] chan_out, led;
	logic [1:0] layout = 2'h3;
	logic [1:0] xq;
	logic mon_a, mon_b, layout_led;
	int hi_cnt [16];
	int mon_cnt;
	int failures = 0;
	int check_count = 0;
	always #20 clk = ~clk;
	gdc_dataway_model m (.i_clock(clk), .i_x(x), .i_q(q), .o_n(n), .o_f(f), .o_a(a),
		.o_w(w), .o_s1(s1), .o_s2(s2), .o_c(c), .o_z(z));
	gdc_top dut (.i_clock(clk), .i_rstn(rstn), .i_n(n), .i_f(f), .i_a(a), .i_w(w),
		.i_s1(s1), .i_s2(s2), .i_c(c), .i_z(z), .i_chan_in(chan_in),
		.i_abort_input(abort_in), .i_inhibit_input(inhibit), .i_fire_all(fire),
		.i_layout_switches(layout), .o_x(x), .o_q(q), .o_chan_out(chan_out),
		.o_monitor_output_a(mon_a), .o_monitor_output_b(mon_b), .o_presence_led(led),
		.o_layout_led(layout_led));
	// Gate lengths are counted in clocks so widths can be judged after the fact
	always @(posedge clk) begin
		for (int k = 0; k < 16; k++) begin
			if (chan_out[k] === 1'b1) begin
				hi_cnt[k]++;
			end
		end
		if (mon_a === 1'b1 && mon_b === 1'b1) begin
			mon_cnt++;
		end
	end
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %0h seen %0h", name, exp, got);
		end
	endtask
	task automatic clr_cnt();
		foreach (hi_cnt[k]) begin
			hi_cnt[k] = 0;
		end
		mon_cnt = 0;
	endtask
	task automatic pulse(input logic all, input int k, input int span);
		clr_cnt();
		@(posedge clk);
		if (all) begin
			fire <= 1'b1;
		end else begin
			chan_in[k] <= 1'b1;
		end
		repeat (4) @(posedge clk);
		fire <= 1'b0;
		chan_in <= 16'h0000;
		repeat (span) @(posedge clk);
	endtask
	// prog: active codes loaded (width k+1), else reset codes (width 1)
	task automatic chk_widths(input logic prog, input int sel);
		for (int k = 0; k < 16; k++) begin
			chk("gate width", prog ? k + 1 : 1, hi_cnt[k]);
		end
		chk("monitor width", prog ? sel + 1 : 1, mon_cnt);
	endtask
	task automatic t_layout_led();
		layout <= 2'h0;
		repeat (4) @(posedge clk);
		chk("layout led off", 1'b0, layout_led);
		layout <= LAYOUT_SINGLE;
		repeat (4) @(posedge clk);
		chk("layout led on", 1'b1, layout_led);
	endtask
	task automatic t_program();
		for (int k = 0; k < 16; k++) begin
			m.cmd(1'b1, FN_DELAY, 4'(k), 8'h10, xq);
			chk("xq delay", 2'h3, xq);
			m.cmd(1'b1, FN_WIDTH, 4'(k), 8'(k), xq);
			chk("xq width", 2'h3, xq);
		end
		m.cmd(1'b1, FN_SELECT, 4'h5, 8'h00, xq);
		pulse(1'b1, 0, 60);
		chk_widths(1'b0, 0);
		m.cmd(1'b1, FN_TRANSFER, SUBADDR_ZERO, 8'h00, xq);
		chk("xq transfer", 2'h3, xq);
		// Sync, edge detect, then delay code 0x10 plus one step before the gate opens
		@(posedge clk);
		fire <= 1'b1;
		repeat (4) @(posedge clk);
		fire <= 1'b0;
		repeat (15) @(posedge clk);
		@(negedge clk);
		chk("gate before delay", 16'h0000, chan_out);
		@(negedge clk);
		chk("gate after delay", 16'hFFFF, chan_out);
		repeat (40) @(posedge clk);
		pulse(1'b1, 0, 60);
		chk_widths(1'b1, 5);
		m.cmd(1'b1, FN_TEST, SUBADDR_ZERO, 8'h00, xq);
		clr_cnt();
		repeat (60) @(posedge clk);
		chk_widths(1'b1, 5);
	endtask
	task automatic t_refused();
		// Staged width differs from the active one, so a wrongly taken transfer shows
		m.cmd(1'b1, FN_WIDTH, 4'hF, 8'h00, xq);
		m.cmd(1'b0, FN_WIDTH, 4'hE, 8'h00, xq);
		chk("xq width no station", 2'h0, xq);
		m.cmd(1'b1, FN_TRANSFER, 4'h1, 8'h00, xq);
		chk("xq f19 a1", 2'h0, xq);
		m.cmd(1'b1, FN_TEST, 4'h1, 8'h00, xq);
		chk("xq f25 a1", 2'h0, xq);
		m.cmd(1'b1, 5'h00, 4'h0, 8'h00, xq);
		chk("xq f0", 2'h0, xq);
		m.cmd(1'b0, FN_RESET, 4'h0, 8'h00, xq);
		chk("xq no station", 2'h0, xq);
		pulse(1'b1, 0, 60);
		chk_widths(1'b1, 5);
		m.cmd(1'b1, FN_WIDTH, 4'hF, 8'h0F, xq);
	endtask
	task automatic t_inputs();
		layout <= 2'h0;
		@(posedge clk);
		chan_in[2] <= 1'b1;
		repeat (5) @(posedge clk);
		chk("presence led", 16'h0004, led);
		chan_in[2] <= 1'b0;
		repeat (60) @(posedge clk);
		pulse(1'b0, 2, 60);
		chk("eight layout out2", 3, hi_cnt[2]);
		chk("eight layout out10", 11, hi_cnt[10]);
		layout <= LAYOUT_SINGLE;
		pulse(1'b0, 2, 60);
		chk("single layout out2", 3, hi_cnt[2]);
		chk("single layout out10", 0, hi_cnt[10]);
	endtask
	task automatic t_abort_inhibit();
		inhibit <= 1'b1;
		pulse(1'b1, 0, 60);
		inhibit <= 1'b0;
		chk("inhibited gate", 0, hi_cnt[15]);
		pulse(1'b1, 0, 21);
		inhibit <= 1'b1; // Raised after the leading edge
		repeat (40) @(posedge clk);
		inhibit <= 1'b0;
		chk("late inhibit", 16, hi_cnt[15]);
		pulse(1'b1, 0, 4);
		abort_in <= 1'b1;
		repeat (4) @(posedge clk);
		abort_in <= 1'b0;
		repeat (60) @(posedge clk);
		chk("aborted gate", 0, hi_cnt[15]);
		chk("aborted monitor", 0, mon_cnt);
	endtask
	task automatic t_resets();
		m.cmd(1'b1, FN_RESET, 4'h0, 8'h00, xq);
		chk("xq reset", 2'h3, xq);
		pulse(1'b1, 0, 60);
		chk_widths(1'b0, 0);
		m.cmd(1'b1, FN_TRANSFER, SUBADDR_ZERO, 8'h00, xq);
		pulse(1'b1, 0, 60);
		chk_widths(1'b1, 0);
		for (int i = 0; i < 2; i++) begin
			m.clear(i[0]);
			pulse(1'b1, 0, 60);
			chk_widths(1'b0, 0);
			m.cmd(1'b1, FN_TRANSFER, SUBADDR_ZERO, 8'h00, xq);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		t_layout_led();
		t_program();
		t_refused();
		t_inputs();
		t_abort_inhibit();
		t_resets();
		report_and_stop();
	end
	// Whole run needs about 1800 clocks
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		report_and_stop();
	end
endmodule
